/* File: bps_pkg.sv */
// constants shared by the pipelined burst sram and its burst address helper
// assumes one 20 MHz clock and a synchronous active-high reset
package bps_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 18;
  localparam int DATA_W  = 16;
  localparam int LANES   = 2;
  localparam int LANE_W  = DATA_W / LANES;
  localparam int WORD_W  = DATA_W + LANES;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int BURST_W = 2;

  // ----------------------------------------------------------------
  // clock and pin filtering
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_STAGES   = 3;
  localparam int PIN_COUNT     = 3;
  localparam int PIN_SLEEP     = 0;
  localparam int PIN_OE        = 1;
  localparam int PIN_ORDER     = 2;
  // sleep off, outputs released, interleaved order
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 3'h6;

  // ----------------------------------------------------------------
  // reset values and states
  // ----------------------------------------------------------------
  localparam logic [BURST_W-1:0] CNT_RESET  = 2'h0;
  localparam logic [BURST_W-1:0] CNT_STEP   = 2'h1;
  localparam logic [LANES-1:0]   LANES_ALL  = 2'h3;
  localparam logic [LANES-1:0]   LANES_NONE = 2'h0;

  typedef enum logic [0:0] {
    ST_DESEL = 1'h0,
    ST_BURST = 1'h1
  } bps_state_t;

endpackage : bps_pkg

/* File: bps_burst_addr.sv */
// low burst address bits from start bits, burst count and order
// assumes the caller registers the count; purely combinational
`timescale 1ns/1ps
`default_nettype none
module bps_burst_addr
  import bps_pkg::*;
(
  input  wire logic [BURST_W-1:0] startBits,
  input  wire logic [BURST_W-1:0] burstCnt,
  input  wire logic               linearMode,
  output logic      [BURST_W-1:0] lowBits
);

  // ----------------------------------------------------------------
  // order decode
  // ----------------------------------------------------------------
  always_comb begin
    if (linearMode) begin
      lowBits = startBits + burstCnt;
    end else begin
      lowBits = startBits ^ burstCnt;
    end
  end

endmodule : bps_burst_addr
`default_nettype wire

/* File: bps_sram.sv */
// pipelined burst sram, 256k words of 16 data and 2 parity bits
// assumes bus inputs are timed to ref_clk; sleep, oe, order pins are not
`timescale 1ns/1ps
`default_nettype none
module bps_sram
  import bps_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic              processorAddrStrobeN,
  input  wire logic              controllerAddrStrobeN,
  input  wire logic              burstAdvanceN,
  input  wire logic              globalWriteN,
  input  wire logic              byteWriteEnableN,
  input  wire logic [LANES-1:0]  byteLaneWriteSelectN,
  input  wire logic              chipSelectOneN,
  input  wire logic              chipSelectTwo,
  input  wire logic              chipSelectThreeN,
  input  wire logic              outputEnableN,
  input  wire logic              sleepRequest,
  input  wire logic              burstOrderSel,
  input  wire logic [DATA_W-1:0] dqIn,
  input  wire logic [LANES-1:0]  parityIn,
  output logic      [DATA_W-1:0] dqOut,
  output logic                   dqOe,
  output logic      [LANES-1:0]  parityOut,
  output logic      [LANES-1:0]  parityOe
);

  // ----------------------------------------------------------------
  // asynchronous pins: three stages, accept when last two agree
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] pinSync_r [PIN_COUNT];
  logic [PIN_COUNT-1:0]   pinVal_r;
  logic [PIN_COUNT-1:0]   pinRaw;

  assign pinRaw = {burstOrderSel, outputEnableN, sleepRequest};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          pinSync_r[gi] <= {SYNC_STAGES{PIN_RESET[gi]}};
          pinVal_r[gi]  <= PIN_RESET[gi];
        end else begin
          pinSync_r[gi] <= {pinSync_r[gi][SYNC_STAGES-2:0], pinRaw[gi]};
          if (pinSync_r[gi][1] == pinSync_r[gi][2]) begin
            pinVal_r[gi] <= pinSync_r[gi][2];
          end
        end
      end
    end
  endgenerate

  logic asleep;
  logic oeOffN;
  logic linearMode;
  assign asleep     = pinVal_r[PIN_SLEEP];
  assign oeOffN     = pinVal_r[PIN_OE];
  assign linearMode = ~pinVal_r[PIN_ORDER];

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addrCap_r;
  logic              procStrbN_r;
  logic              ctrlStrbN_r;
  logic              stepN_r;
  logic              globWrN_r;
  logic              byteWrEnN_r;
  logic [LANES-1:0]  laneSelN_r;
  logic              csOneN_r;
  logic              csTwo_r;
  logic              csThreeN_r;
  logic [WORD_W-1:0] wrWord_r;

  // no reset needed: these only ever hold last sampled pins
  always_ff @(posedge ref_clk) begin
    addrCap_r   <= addrIn;
    procStrbN_r <= processorAddrStrobeN;
    ctrlStrbN_r <= controllerAddrStrobeN;
    stepN_r     <= burstAdvanceN;
    globWrN_r   <= globalWriteN;
    byteWrEnN_r <= byteWriteEnableN;
    laneSelN_r  <= byteLaneWriteSelectN;
    csOneN_r    <= chipSelectOneN;
    csTwo_r     <= chipSelectTwo;
    csThreeN_r  <= chipSelectThreeN;
    wrWord_r    <= {parityIn, dqIn};
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  function automatic logic [LANES-1:0] laneMask(input logic gwN, input logic bweN,
                                                input logic [LANES-1:0] selN);
    if (!gwN) begin
      laneMask = LANES_ALL;
    end else if (!bweN) begin
      laneMask = ~selN;
    end else begin
      laneMask = LANES_NONE;
    end
  endfunction : laneMask

  bps_state_t        state_r;
  bps_state_t        state_nxt;
  logic [ADDR_W-1:0] baseAddr_r;
  logic [ADDR_W-1:0] baseAddr_nxt;
  logic [BURST_W-1:0] burstCnt_r;
  logic [BURST_W-1:0] burstCnt_nxt;
  logic              selected;
  logic              procValid;
  logic              ctrlValid;
  logic              strobe;
  logic              accessNow;
  logic [LANES-1:0]  wrLanes;
  logic              isWrite;
  logic              isRead;
  logic [BURST_W-1:0] lowBits;
  logic [ADDR_W-1:0] effAddr;

  assign selected  = ~csOneN_r & csTwo_r & ~csThreeN_r;
  assign procValid = ~procStrbN_r & ~csOneN_r & ~asleep;
  assign ctrlValid = ~ctrlStrbN_r & ~procValid & ~asleep;
  assign strobe    = procValid | ctrlValid;
  assign accessNow = ~asleep & (strobe ? selected : (state_r == ST_BURST));
  assign wrLanes   = laneMask(globWrN_r, byteWrEnN_r, laneSelN_r);
  assign isWrite   = accessNow & (wrLanes != LANES_NONE);
  assign isRead    = accessNow & (wrLanes == LANES_NONE);

  always_comb begin
    state_nxt    = state_r;
    baseAddr_nxt = baseAddr_r;
    burstCnt_nxt = burstCnt_r;
    if (strobe) begin
      if (selected) begin
        state_nxt    = ST_BURST;
        baseAddr_nxt = addrCap_r;
        burstCnt_nxt = CNT_RESET;
      end else begin
        state_nxt    = ST_DESEL;
      end
    end else if (!asleep && state_r == ST_BURST && !stepN_r) begin
      burstCnt_nxt = burstCnt_r + CNT_STEP;
    end
  end

  // the word used this edge: fresh address on a selected strobe, else burst step
  bps_burst_addr u_burst_addr (
    .startBits  (baseAddr_nxt[BURST_W-1:0]),
    .burstCnt   (burstCnt_nxt),
    .linearMode (linearMode),
    .lowBits    (lowBits)
  );
  assign effAddr = {baseAddr_nxt[ADDR_W-1:BURST_W], lowBits};

  // ----------------------------------------------------------------
  // storage and output registers
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] rdWord_r;
  logic [WORD_W-1:0] rdWord_nxt;
  logic              drive_r;
  logic              drive_nxt;

  // single-edge write; no strobe shaping needed outside
  always_ff @(posedge ref_clk) begin
    for (int ln = 0; ln < LANES; ln++) begin
      if (isWrite && wrLanes[ln]) begin
        mem[effAddr][ln*LANE_W +: LANE_W] <= wrWord_r[ln*LANE_W +: LANE_W];
        mem[effAddr][DATA_W + ln]         <= wrWord_r[DATA_W + ln];
      end
    end
  end

  always_comb begin
    rdWord_nxt = rdWord_r;
    if (isRead) begin
      rdWord_nxt = mem[effAddr];
    end
    // oe is sampled, so release lags the pin by the filter depth
    drive_nxt = isRead & (state_r != ST_DESEL) & ~oeOffN;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r    <= ST_DESEL;
      baseAddr_r <= '0;
      burstCnt_r <= CNT_RESET;
      rdWord_r   <= '0;
      drive_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      baseAddr_r <= baseAddr_nxt;
      burstCnt_r <= burstCnt_nxt;
      rdWord_r   <= rdWord_nxt;
      drive_r    <= drive_nxt;
    end
  end

  assign dqOut     = rdWord_r[DATA_W-1:0];
  assign parityOut = rdWord_r[WORD_W-1:DATA_W];
  assign dqOe      = drive_r;
  assign parityOe  = {LANES{drive_r}};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_STROBE_LOAD: assert property (
    strobe && selected |=> baseAddr_r == $past(addrCap_r) && burstCnt_r == CNT_RESET)
    else $error("address not captured on selected strobe");
  AST_HOLD_NO_STEP: assert property (
    !strobe && !asleep && state_r == ST_BURST && stepN_r |=> $stable(burstCnt_r))
    else $error("burst count moved without advance");
  AST_STEP: assert property (
    !strobe && !asleep && state_r == ST_BURST && !stepN_r
      |=> burstCnt_r == $past(burstCnt_r) + CNT_STEP)
    else $error("burst count did not step");
  AST_PROC_IGNORED: assert property (
    csOneN_r && ctrlStrbN_r |=> $stable(baseAddr_r))
    else $error("processor strobe taken with select one high");
  AST_PROC_WINS: assert property (
    !procStrbN_r && !csOneN_r && !asleep && !ctrlStrbN_r && selected
      |=> baseAddr_r == $past(addrCap_r) && state_r == ST_BURST)
    else $error("controller strobe disturbed processor access");
  AST_DESELECT: assert property (
    strobe && !selected |=> state_r == ST_DESEL ##1 !drive_r)
    else $error("deselect did not end burst");
  AST_FIRST_MASK: assert property (
    isRead && state_r == ST_DESEL |=> !dqOe)
    else $error("pins driven on first read after deselect");
  AST_WRITE_QUIET: assert property (
    accessNow && !globWrN_r |=> !dqOe && parityOe == LANES_NONE)
    else $error("global write cycle drove pins");
  AST_DRIVE_CAUSE: assert property (
    dqOe |-> $past(isRead) && !$past(oeOffN))
    else $error("pins driven without read and enable");
  AST_SLEEP_QUIET: assert property (
    asleep [*2] |=> !dqOe)
    else $error("pins driven while asleep");
  AST_ORDER: assert property (
    (linearMode ? lowBits - baseAddr_nxt[BURST_W-1:0] : lowBits ^ baseAddr_nxt[BURST_W-1:0])
      == burstCnt_nxt)
    else $error("burst address does not follow burst order");

endmodule : bps_sram
`default_nettype wire

/* File: bps_bus_master.sv */
// bus master model: processor and cache controller on one shared bus
// assumes the bench merges dq wires and calls put once per clock cycle
`timescale 1ns/1ps
`default_nettype none
module bps_bus_master
  import bps_pkg::*;
(
  input  wire logic              ref_clk,
  output logic      [ADDR_W-1:0] addrIn,
  output logic                   processorAddrStrobeN,
  output logic                   controllerAddrStrobeN,
  output logic                   burstAdvanceN,
  output logic                   globalWriteN,
  output logic                   byteWriteEnableN,
  output logic      [LANES-1:0]  byteLaneWriteSelectN,
  output logic                   chipSelectOneN,
  output logic                   chipSelectTwo,
  output logic                   chipSelectThreeN,
  output logic      [WORD_W-1:0] wData
);
  // ----------------------------------------------------------------
  // bus cycle
  // ----------------------------------------------------------------
  initial begin
    {processorAddrStrobeN, controllerAddrStrobeN, burstAdvanceN} = 3'h7;
    {globalWriteN, byteWriteEnableN, byteLaneWriteSelectN} = 4'hf;
    {chipSelectOneN, chipSelectTwo, chipSelectThreeN} = 3'h2;
    addrIn = '0;
    wData = '0;
  end

  // cs: 0 selected, 1 two low, 2 one high, 3 three high
  task automatic put(input logic [1:0] strb, input logic burst_advance_n, input logic [3:0] wr,
                     input logic [1:0] cs, input logic [ADDR_W-1:0] a,
                     input logic [WORD_W-1:0] d);
    @(posedge ref_clk);
    #2;
    {processorAddrStrobeN, controllerAddrStrobeN} = strb;
    burstAdvanceN = burst_advance_n;
    {globalWriteN, byteWriteEnableN, byteLaneWriteSelectN} = wr;
    {chipSelectOneN, chipSelectTwo, chipSelectThreeN} =
      (cs == 2'h1) ? 3'h0 : (cs == 2'h2) ? 3'h6 : (cs == 2'h3) ? 3'h3 : 3'h2;
    addrIn = a;
    // released lines flip so a stale value never looks valid
    wData = (wr != 4'hf) ? d : ~wData;
  endtask : put
endmodule : bps_bus_master
`default_nettype wire

/* File: test_burst_pipelined_sync_sram.sv */
// self-checking bench for the pipelined burst sram
// assumes the master model drives the bus; bench merges dq wires
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin errTotal++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_burst_pipelined_sync_sram;
  import bps_pkg::*;
  localparam logic [ADDR_W-1:0] BASE = 18'h2a5c4;
  localparam logic [3:0]        RD   = 4'hf;
  localparam logic [3:0]        GW   = 4'h7;
  localparam logic [WORD_W-1:0] LM   = 18'h100ff;
  logic ref_clk, srst, outputEnableN, sleepRequest, burstOrderSel, dqOe;
  logic processorAddrStrobeN, controllerAddrStrobeN, burstAdvanceN, globalWriteN;
  logic byteWriteEnableN, chipSelectOneN, chipSelectTwo, chipSelectThreeN;
  logic [ADDR_W-1:0] addrIn;
  logic [LANES-1:0]  byteLaneWriteSelectN, parityOut, parityOe;
  logic [DATA_W-1:0] dqOut;
  logic [WORD_W-1:0] wData;
  int                errTotal = 0;
  int                samplesChecked = 0;
  wire logic [DATA_W-1:0] dqWire  = dqOe ? dqOut : wData[DATA_W-1:0];
  wire logic [LANES-1:0]  parWire = (parityOe & parityOut) | (~parityOe & wData[WORD_W-1:DATA_W]);
  wire logic [WORD_W-1:0] rWord   = {parityOut, dqOut};

  bps_sram bps_sram_inst (.ref_clk, .srst, .addrIn, .processorAddrStrobeN,
    .controllerAddrStrobeN, .burstAdvanceN, .globalWriteN, .byteWriteEnableN,
    .byteLaneWriteSelectN, .chipSelectOneN, .chipSelectTwo, .chipSelectThreeN,
    .outputEnableN, .sleepRequest, .burstOrderSel, .dqIn(dqWire), .parityIn(parWire),
    .dqOut, .dqOe, .parityOut, .parityOe);
  bps_bus_master bps_bus_master_inst (.ref_clk, .addrIn, .processorAddrStrobeN,
    .controllerAddrStrobeN, .burstAdvanceN, .globalWriteN, .byteWriteEnableN,
    .byteLaneWriteSelectN, .chipSelectOneN, .chipSelectTwo, .chipSelectThreeN, .wData);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic put(input logic [1:0] s, input logic v, input logic [3:0] w,
                     input logic [1:0] c, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    bps_bus_master_inst.put(s, v, w, c, a, d);
  endtask : put

  function automatic logic [WORD_W-1:0] wd(input int i);
    return {i[1:0], 8'h30 + 8'(i), 8'hc0 + 8'(i)};
  endfunction : wd

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_fill();
    for (int i = 0; i < 4; i++) begin
      put(2'h2, 1'b1, GW, 2'h0, BASE + 18'(i), wd(i));
      `CHK("write oe", 1'b0, dqOe)
    end
    $display("fill done");
  endtask : t_fill

  // data shows two edges after the beat, so check lags two puts
  task automatic t_order(input logic mode);
    int b;
    burstOrderSel = mode;
    repeat (5) put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    put(2'h2, 1'b1, RD, 2'h1, '0, '0);
    for (int j = 0; j < 6; j++) begin
      put((j == 0) ? 2'h1 : 2'h3, (j == 0 || j > 3), RD, 2'h0, BASE + 18'h1, '0);
      b = j - 2;
      if (j >= 2) `CHK("burst oe", (b != 0), dqOe)
      if (j >= 2) `CHK("burst word", wd(mode ? (1 ^ b) : ((1 + b) % 4)), rWord)
    end
    $display("order %0d done", mode);
  endtask : t_order

  task automatic t_ce1();
    put(2'h0, 1'b1, RD, 2'h0, BASE + 18'h2, '0);
    put(2'h1, 1'b0, RD, 2'h2, '0, '0);
    for (int j = 2; j < 5; j++) begin
      put(2'h3, 1'b1, RD, 2'h0, '0, '0);
      `CHK("ce1 oe", 1'b1, dqOe)
      `CHK("ce1 word", wd((j == 2) ? 2 : 3), rWord)
    end
    $display("ce1 done");
  endtask : t_ce1

  task automatic t_bytes();
    logic [WORD_W-1:0] ex [3] = '{(wd(0) & ~LM) | (18'h2abcd & LM), 18'h15a5a, wd(2)};
    // turn the bus around: read beats would still drive dq when write data is taken
    put(2'h2, 1'b1, RD, 2'h1, '0, '0);
    put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    put(2'h2, 1'b1, 4'ha, 2'h0, BASE, 18'h2abcd);
    put(2'h2, 1'b1, 4'h5, 2'h0, BASE + 18'h1, 18'h15a5a);
    put(2'h2, 1'b1, 4'hc, 2'h0, BASE + 18'h2, 18'h3ffff);
    for (int j = 0; j < 5; j++) begin
      put((j < 3) ? 2'h2 : 2'h3, 1'b1, RD, 2'h0, BASE + 18'(j), '0);
      if (j >= 2) `CHK("lane word", ex[j - 2], rWord)
    end
    $display("bytes done");
  endtask : t_bytes

  task automatic t_desel();
    for (int c = 1; c < 4; c += 2) begin
      put(2'h2, 1'b1, RD, 2'h0, BASE, '0);
      put(2'h2, 1'b1, RD, 2'(c), BASE, '0);
      for (int j = 0; j < 4; j++) begin
        put(2'h3, 1'b0, RD, 2'h0, BASE, '0);
        if (j > 0) `CHK("desel oe", 1'b0, dqOe)
      end
    end
    $display("desel done");
  endtask : t_desel

  task automatic t_oe_sleep();
    put(2'h2, 1'b1, RD, 2'h0, BASE, '0);
    outputEnableN = 1'b1;
    repeat (6) put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    `CHK("oe high", 1'b0, dqOe)
    outputEnableN = 1'b0;
    repeat (6) put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    `CHK("oe low", 1'b1, dqOe)
    `CHK("parity oe", 2'h3, parityOe)
    sleepRequest = 1'b1;
    // sleep pin filter lags, so let it settle before the blocked writes
    repeat (4) put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    repeat (6) put(2'h2, 1'b1, GW, 2'h0, BASE + 18'h3, 18'h0);
    `CHK("sleep oe", 1'b0, dqOe)
    sleepRequest = 1'b0;
    repeat (5) put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    put(2'h2, 1'b1, RD, 2'h0, BASE + 18'h3, '0);
    repeat (2) put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    `CHK("sleep word", wd(3), rWord)
    $display("oe sleep done");
  endtask : t_oe_sleep

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // a hang is cut after far more cycles than the tests need
  initial begin
    #(4000 * 50);
    errTotal++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    outputEnableN = 1'b0;
    sleepRequest = 1'b0;
    burstOrderSel = 1'b1;
    repeat (8) @(posedge ref_clk);
    #2 srst = 1'b0;
    repeat (5) put(2'h3, 1'b1, RD, 2'h0, '0, '0);
    t_fill();
    t_order(1'b0);
    t_order(1'b1);
    t_ce1();
    t_bytes();
    t_desel();
    t_oe_sleep();
    print_verdict();
  end
endmodule : test_burst_pipelined_sync_sram
`default_nettype wire
